// ---- eth_pkt_fifo_mgmt.sv ----
// module: receive and transmit packet fifos with phy management and power control
// Notes on behaviour
// - readable count of complete received packets
// - count rises on error-free frame end
// - count falls once whole packet drained
// - receive fifo keeps checksum trailer bytes
// - transmit fifo holds exactly one packet
// - transmitter busy until sent; no reload meanwhile
// - phy power comes up on after reset
// - powered-off phy cannot hold a link
// - management read returns sixteen bits
// - management write puts data at register
// - programmable phy address for external phy
// - management-done flag on completed transaction
// - receive flag while packets are held
// - transmit-done flag after successful send
// - overrun flag when frame exceeds space
`timescale 1ns/10ps
module eth_pkt_fifo_mgmt (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // receive side from the mac
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_last_i,
   input wire logic rx_err_i,
   // receive drain by software
   input wire logic rx_pop_i,
   output logic [7:0] rx_rd_data_o,
   output logic rx_rd_last_o,
   output logic rx_rd_valid_o,
   output logic [eth_pkt_pkg::CNT_W-1:0] rx_pkt_count_o,
   // transmit load by software
   input wire logic tx_push_i,
   input wire logic [7:0] tx_push_data_i,
   input wire logic tx_req_set_i,
   output logic tx_req_o,
   // transmit side to the mac
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   output logic tx_last_o,
   input wire logic tx_ready_i,
   // phy management and power
   input wire logic phy_addr_we_i,
   input wire logic [eth_pkt_pkg::PHY_ADDR_W-1:0] phy_addr_i,
   input wire logic mgmt_start_i,
   input wire logic mgmt_write_i,
   input wire logic [eth_pkt_pkg::PHY_REG_W-1:0] mgmt_reg_i,
   input wire logic [eth_pkt_pkg::PHY_DATA_W-1:0] mgmt_wdata_i,
   output logic mgmt_busy_o,
   output logic [eth_pkt_pkg::PHY_DATA_W-1:0] mgmt_rdata_o,
   input wire logic phy_power_off_i,
   input wire logic phy_power_on_i,
   output logic phy_power_o,
   input wire logic link_up_i,
   output logic link_ok_o,
   // event flags, cleared by one-cycle pulses
   input wire logic [3:0] flag_clr_i,
   output logic mgmt_done_flag_o,
   output logic rx_packet_flag_o,
   output logic tx_done_flag_o,
   output logic rx_overrun_flag_o,
   // phy serial pins
   output logic mdc_o,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_o
);
   import eth_pkt_pkg::*;
   //////////////////////////////////////////////////////////////////////
   // storage: receive entries hold data byte plus end-of-packet marker; transmit entries hold the data byte only
   logic [8:0] rx_mem [RX_DEPTH];
   logic [7:0] tx_mem [TX_DEPTH];
   typedef struct packed {
      logic [RX_AW:0] rx_wp;       // committed write pointer
      logic [RX_AW:0] rx_tp;       // tentative write pointer of frame in flight
      logic [RX_AW:0] rx_rp;
      logic rx_drop;               // frame being discarded
      logic [CNT_W-1:0] cnt;
      logic [7:0] rd_data;
      logic rd_last;
      logic rd_valid;
      logic [TX_AW:0] tx_wp;
      logic [TX_AW:0] tx_rp;
      tx_state_type tx_st;
      logic tx_req;
      logic tx_valid;
      logic [7:0] tx_data;
      logic tx_last;
      logic [PHY_ADDR_W-1:0] phy_addr;
      logic mgmt_busy;
      logic [PHY_DATA_W-1:0] mgmt_rdata;
      logic power;
      logic link;
      logic f_mgmt;
      logic f_rx;
      logic f_tx;
      logic f_ovr;
   } st_type;
   st_type r, next_r;
   mgmt_if m();
   logic rx_wr_en;
   logic tx_wr_en;
   logic [8:0] rx_head;
   logic [RX_AW:0] rx_used;
   //////////////////////////////////////////////////////////////////////
   // serial engine to the phy
   mgmt_serial u_ser (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .m(m),
      .mdio_i(mdio_i),
      .mdc_o(mdc_o),
      .mdio_o(mdio_o),
      .mdio_oe_o(mdio_oe_o)
   );
   assign m.start = mgmt_start_i && !r.mgmt_busy;
   assign m.write = mgmt_write_i;
   assign m.phy_addr = r.phy_addr; // programmed address used by every access
   assign m.reg_addr = mgmt_reg_i;
   assign m.wdata = mgmt_wdata_i; // write data placed at the addressed register
   assign rx_head = rx_mem[r.rx_rp[RX_AW-1:0]];
   assign rx_used = r.rx_tp - r.rx_rp;
   //////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_r = r;
      rx_wr_en = 1'b0;
      tx_wr_en = 1'b0;
      next_r.rd_valid = 1'b0;
      // receive fill; trailer bytes stored like any other
      if (rx_valid_i && !r.rx_drop) begin
         if (rx_used[RX_AW]) begin
            // no room for this frame: roll back and flag
            next_r.rx_tp = r.rx_wp;
            next_r.rx_drop = !rx_last_i;
            next_r.f_ovr = 1'b1;
         end else begin
            rx_wr_en = 1'b1;
            next_r.rx_tp = r.rx_tp + 1'b1;
            if (rx_last_i) begin
               if (rx_err_i) begin
                  next_r.rx_tp = r.rx_wp; // bad frame discarded
               end else begin
                  next_r.rx_wp = r.rx_tp + 1'b1;
               end
            end
         end
      end else if (rx_valid_i && rx_last_i) begin
         next_r.rx_drop = 1'b0;
      end
      // receive drain by software, one byte per pop
      if (rx_pop_i && r.rx_rp != r.rx_wp) begin
         next_r.rx_rp = r.rx_rp + 1'b1;
         next_r.rd_data = rx_head[7:0];
         next_r.rd_last = rx_head[8];
         next_r.rd_valid = 1'b1;
      end
      // count: up on good frame end, down when last byte read
      next_r.cnt = r.cnt + CNT_W'(rx_wr_en && rx_last_i && !rx_err_i)
                   - CNT_W'(rx_pop_i && r.rx_rp != r.rx_wp && rx_head[8]);
      if (next_r.cnt != '0) begin
         next_r.f_rx = 1'b1;
      end else if (flag_clr_i[1]) begin
         next_r.f_rx = 1'b0;
      end
      // transmit: single packet; loads ignored while request pending
      case (r.tx_st)
         TX_IDLE: begin
            if (tx_push_i && !r.tx_wp[TX_AW]) begin
               tx_wr_en = 1'b1;
               next_r.tx_wp = r.tx_wp + 1'b1;
            end
            if (tx_req_set_i && r.tx_wp != '0) begin
               next_r.tx_req = 1'b1; // launched by software
               next_r.tx_st = TX_SEND;
            end
         end
         TX_SEND: begin
            if (!r.tx_valid || tx_ready_i) begin
               if (r.tx_rp != r.tx_wp) begin
                  next_r.tx_valid = 1'b1;
                  next_r.tx_data = tx_mem[r.tx_rp[TX_AW-1:0]];
                  next_r.tx_last = (r.tx_rp + 1'b1) == r.tx_wp;
                  next_r.tx_rp = r.tx_rp + 1'b1;
               end else begin
                  next_r.tx_valid = 1'b0;
                  next_r.tx_last = 1'b0;
                  next_r.tx_st = TX_DONE;
               end
            end
         end
         TX_DONE: begin
            next_r.tx_req = 1'b0; // self-clears, fifo reloadable
            next_r.tx_wp = '0;
            next_r.tx_rp = '0;
            next_r.f_tx = 1'b1;
            next_r.tx_st = TX_IDLE;
         end
         default: begin
            next_r.tx_st = TX_IDLE;
         end
      endcase
      // phy address and power
      if (phy_addr_we_i) begin
         next_r.phy_addr = phy_addr_i;
      end
      if (phy_power_off_i) begin
         next_r.power = 1'b0;
      end else if (phy_power_on_i) begin
         next_r.power = 1'b1;
      end
      next_r.link = next_r.power && link_up_i; // no link while off
      // management handshake
      next_r.mgmt_busy = m.busy || m.start;
      if (m.done) begin
         next_r.mgmt_rdata = m.rdata;
      end
      // sticky flags: a set beats a same-cycle clear
      next_r.f_mgmt = m.done || (r.f_mgmt && !flag_clr_i[0]);
      if (r.tx_st != TX_DONE && flag_clr_i[2]) begin
         next_r.f_tx = 1'b0;
      end
      if (!(rx_valid_i && !r.rx_drop && rx_used[RX_AW]) && flag_clr_i[3]) begin
         next_r.f_ovr = 1'b0;
      end
   end
   //////////////////////////////////////////////////////////////////////
   // memories, written without reset
   always_ff @(posedge sys_clk_i) begin
      if (rx_wr_en) begin
         rx_mem[r.rx_tp[RX_AW-1:0]] <= {rx_last_i, rx_data_i};
      end
      if (tx_wr_en) begin
         tx_mem[r.tx_wp[TX_AW-1:0]] <= tx_push_data_i;
      end
   end
   //////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         r <= '0;
         r.tx_st <= TX_IDLE;
         r.power <= 1'b1; // powered on out of reset
         r.phy_addr <= PHY_ADDR_RESET;
      end else begin
         r <= next_r;
      end
   end
   assign rx_pkt_count_o = r.cnt;
   assign rx_rd_data_o = r.rd_data;
   assign rx_rd_last_o = r.rd_last;
   assign rx_rd_valid_o = r.rd_valid;
   assign tx_req_o = r.tx_req; // in progress indication
   assign tx_valid_o = r.tx_valid;
   assign tx_data_o = r.tx_data;
   assign tx_last_o = r.tx_last;
   assign mgmt_busy_o = r.mgmt_busy;
   assign mgmt_rdata_o = r.mgmt_rdata;
   assign phy_power_o = r.power;
   assign link_ok_o = r.link;
   assign mgmt_done_flag_o = r.f_mgmt;
   assign rx_packet_flag_o = r.f_rx;
   assign tx_done_flag_o = r.f_tx;
   assign rx_overrun_flag_o = r.f_ovr;
endmodule

// ---- eth_pkt_fifo_mgmt_sva.sv ----
// checker: timing relations at the ports of the packet fifo and phy management block
`timescale 1ns/10ps
module eth_pkt_fifo_mgmt_sva (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic rx_valid_i,
   input wire logic rx_last_i,
   input wire logic rx_err_i,
   input wire logic rx_rd_valid_o,
   input wire logic rx_rd_last_o,
   input wire logic [eth_pkt_pkg::CNT_W-1:0] rx_pkt_count_o,
   input wire logic rx_packet_flag_o,
   input wire logic tx_req_o,
   input wire logic tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   input wire logic tx_done_flag_o,
   input wire logic mgmt_start_i,
   input wire logic mgmt_busy_o,
   input wire logic mgmt_done_flag_o,
   input wire logic phy_power_o,
   input wire logic link_ok_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // cycles spent busy; one frame must take its full serial length
   logic [11:0] busy_len;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || !mgmt_busy_o) begin
         busy_len <= 12'h000;
      end else begin
         busy_len <= busy_len + 12'h001;
      end
   end
   a_power_on_reset: assert property (disable iff (1'b0) sys_rst_i |=> phy_power_o)
      else $error("phy power not on after reset");
   a_link_gated_off: assert property (!phy_power_o |-> !link_ok_o)
      else $error("link shown while phy powered off");
   a_count_rise_cause: assert property (!(rx_valid_i && rx_last_i && !rx_err_i)
      |=> rx_pkt_count_o <= $past(rx_pkt_count_o))
      else $error("packet count rose without good frame end");
   a_count_fall_cause: assert property ((rx_pkt_count_o < $past(rx_pkt_count_o))
      |-> rx_rd_valid_o && rx_rd_last_o)
      else $error("packet count fell without last byte read");
   a_rx_flag_held: assert property (rx_pkt_count_o != 7'h00 |-> rx_packet_flag_o)
      else $error("receive flag low while packets held");
   a_tx_under_req: assert property (tx_valid_o |-> tx_req_o)
      else $error("transmit stream without request");
   a_tx_hold_stall: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("transmit byte dropped while stalled");
   a_tx_done_clear: assert property ($fell(tx_req_o) |-> tx_done_flag_o)
      else $error("request cleared without done flag");
   a_mgmt_busy_rise: assert property (mgmt_start_i && !mgmt_busy_o |=> mgmt_busy_o)
      else $error("management start not shown busy");
   a_mgmt_frame_len: assert property ($fell(mgmt_busy_o) |-> busy_len >= 12'hA00 && busy_len <= 12'hA28)
      else $error("management busy length off");
   a_mgmt_done_flag: assert property ($fell(mgmt_busy_o) |-> ##[0:2] mgmt_done_flag_o)
      else $error("management done flag missing");
endmodule
bind eth_pkt_fifo_mgmt eth_pkt_fifo_mgmt_sva chk (.sys_clk_i, .sys_rst_i, .rx_valid_i, .rx_last_i, .rx_err_i,
   .rx_rd_valid_o, .rx_rd_last_o, .rx_pkt_count_o, .rx_packet_flag_o, .tx_req_o, .tx_valid_o, .tx_data_o,
   .tx_ready_i, .tx_done_flag_o, .mgmt_start_i, .mgmt_busy_o, .mgmt_done_flag_o, .phy_power_o, .link_ok_o);

// ---- eth_pkt_fifo_mgmt_test.sv ----
// testbench: receive, transmit, management and power scenarios
`timescale 1ns/10ps
module eth_pkt_fifo_mgmt_test;
   import eth_pkt_pkg::*;
   logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, rx_valid_i = 1'b0, rx_last_i = 1'b0, rx_err_i = 1'b0;
   logic rx_pop_i = 1'b0, tx_push_i = 1'b0, tx_req_set_i = 1'b0, tx_ready_i = 1'b0, phy_addr_we_i = 1'b0;
   logic mgmt_start_i = 1'b0, mgmt_write_i = 1'b0, phy_power_off_i = 1'b0, phy_power_on_i = 1'b0, link_up_i = 1'b0;
   logic [7:0] rx_data_i = 8'h00, tx_push_data_i = 8'h00, rx_rd_data_o, tx_data_o;
   logic [4:0] phy_addr_i = 5'h00, mgmt_reg_i = 5'h00;
   logic [15:0] mgmt_wdata_i = 16'h0000, mgmt_rdata_o;
   logic [3:0] flag_clr_i = 4'h0;
   logic [CNT_W-1:0] rx_pkt_count_o;
   logic rx_rd_last_o, rx_rd_valid_o, tx_req_o, tx_valid_o, tx_last_o, mgmt_busy_o, phy_power_o, link_ok_o;
   logic mgmt_done_flag_o, rx_packet_flag_o, tx_done_flag_o, rx_overrun_flag_o, mdc_o, mdio_o, mdio_oe_o;
   logic phy_o, phy_oe;
   wire logic mdio_w = phy_oe ? phy_o : (mdio_oe_o ? mdio_o : 1'b1); // pulled up when nobody drives
   int fails = 0, samples_checked = 0, cycles = 0;
   eth_pkt_fifo_mgmt dut (.sys_clk_i, .sys_rst_i, .rx_valid_i, .rx_data_i, .rx_last_i, .rx_err_i, .rx_pop_i,
      .rx_rd_data_o, .rx_rd_last_o, .rx_rd_valid_o, .rx_pkt_count_o, .tx_push_i, .tx_push_data_i, .tx_req_set_i,
      .tx_req_o, .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i, .phy_addr_we_i, .phy_addr_i, .mgmt_start_i,
      .mgmt_write_i, .mgmt_reg_i, .mgmt_wdata_i, .mgmt_busy_o, .mgmt_rdata_o, .phy_power_off_i, .phy_power_on_i,
      .phy_power_o, .link_up_i, .link_ok_o, .flag_clr_i, .mgmt_done_flag_o, .rx_packet_flag_o, .tx_done_flag_o,
      .rx_overrun_flag_o, .mdc_o, .mdio_i(mdio_w), .mdio_o, .mdio_oe_o);
   phy_mgmt_model #(.PHY_AT(5'h03)) phy (.mdc_i(mdc_o), .mdio_i(mdio_w), .mdio_o(phy_o), .mdio_oe_o(phy_oe));
   initial begin
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // hang guard, well above the three management frames
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         print_verdict();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge sys_clk_i);
   endtask
   // back-to-back bytes, the last one marked and carrying the error bit
   task automatic rx_frame(input int len, input logic err);
      for (int i = 0; i < len; i++) begin
         rx_valid_i = 1'b1;
         rx_data_i = 8'(8'h30 + i);
         rx_last_i = (i == len - 1);
         rx_err_i = err && (i == len - 1);
         tick(1);
      end
      rx_valid_i = 1'b0;
      rx_last_i = 1'b0;
      rx_err_i = 1'b0;
      tick(1);
   endtask
   task automatic test_rx();
      rx_frame(4, 1'b1);
      check(rx_pkt_count_o, 0);
      rx_frame(4, 1'b0);
      check(rx_pkt_count_o, 1);
      check(rx_packet_flag_o, 1);
      rx_pop_i = 1'b1;
      for (int i = 0; i < 4; i++) begin
         tick(1);
         check(rx_rd_valid_o, 1);
         check({rx_rd_last_o, rx_rd_data_o}, {i == 3, 8'(8'h30 + i)});
      end
      rx_pop_i = 1'b0;
      check(rx_pkt_count_o, 0);
      flag_clr_i = 4'h2;
      tick(1);
      flag_clr_i = 4'h0;
      tick(1);
      check(rx_packet_flag_o, 0);
   endtask
   task automatic test_overrun();
      rx_frame(RX_DEPTH + 6, 1'b0);
      check(rx_overrun_flag_o, 1);
      check(rx_pkt_count_o, 0);
   endtask
   task automatic test_tx();
      int got = 0;
      for (int i = 0; i < 4; i++) begin
         tx_push_i = 1'b1;
         tx_push_data_i = (i == 3) ? 8'hEE : 8'(8'hA0 + i);
         tx_req_set_i = (i == 2); // start with the third byte; the fourth push lands in TX_SEND and is ignored
         tick(1);
      end
      tx_push_i = 1'b0;
      tx_req_set_i = 1'b0;
      check(tx_req_o, 1);
      for (int c = 0; c < 60 && tx_req_o !== 1'b0; c++) begin
         tx_ready_i = c[0];
         if (tx_valid_o === 1'b1 && c[0]) begin
            check({tx_last_o, tx_data_o}, {got == 2, 8'(8'hA0 + got)});
            got++;
         end
         tick(1);
      end
      tx_ready_i = 1'b0;
      check(16'(got), 3);
      check({tx_req_o, tx_done_flag_o}, 2'b01);
      tx_req_set_i = 1'b1;
      tick(1);
      tx_req_set_i = 1'b0;
      tick(1);
      check(tx_req_o, 0);
   endtask
   task automatic mgmt(input logic wr, input logic [15:0] wd, input logic [15:0] exp);
      mgmt_start_i = 1'b1;
      mgmt_write_i = wr;
      mgmt_reg_i = 5'h04;
      mgmt_wdata_i = wd;
      tick(1);
      mgmt_start_i = 1'b0;
      check(mgmt_busy_o, 1);
      // while the phy answers, our side must have let go of the line
      for (int c = 0; c < 3000 && mgmt_busy_o !== 1'b0; c++) begin
         tick(1);
         if (phy_oe) check(mdio_oe_o, 0);
      end
      tick(2);
      check(mgmt_done_flag_o, 1);
      if (!wr) check(mgmt_rdata_o, exp);
      flag_clr_i = 4'h1;
      tick(1);
      flag_clr_i = 4'h0;
   endtask
   task automatic test_mgmt();
      phy_addr_we_i = 1'b1;
      phy_addr_i = 5'h03;
      tick(1);
      phy_addr_we_i = 1'b0;
      mgmt(1'b1, 16'hBEEF, 16'h0000);
      mgmt(1'b0, 16'h0000, 16'hBEEF);
      phy_addr_we_i = 1'b1;
      phy_addr_i = 5'h07;
      tick(1);
      phy_addr_we_i = 1'b0;
      mgmt(1'b0, 16'h0000, 16'hFFFF);
   endtask
   task automatic test_power();
      link_up_i = 1'b1;
      tick(2);
      check(link_ok_o, 1);
      phy_power_off_i = 1'b1;
      phy_power_on_i = 1'b1;
      tick(1);
      phy_power_off_i = 1'b0;
      phy_power_on_i = 1'b0;
      tick(1);
      check({phy_power_o, link_ok_o}, 2'b00);
      phy_power_on_i = 1'b1;
      tick(1);
      phy_power_on_i = 1'b0;
      tick(1);
      check({phy_power_o, link_ok_o}, 2'b11);
   endtask
   initial begin
      tick(8);
      sys_rst_i = 1'b0;
      check({phy_power_o, mgmt_busy_o, tx_req_o, rx_pkt_count_o}, {3'b100, 7'h00});
      test_rx();
      test_overrun();
      test_tx();
      test_mgmt();
      test_power();
      print_verdict();
   end
endmodule

// ---- eth_pkt_pkg.sv ----
// package: constants and types shared by the packet fifo and phy management block
package eth_pkt_pkg;
   localparam int RX_DEPTH = 64;
   localparam int RX_AW = 6;
   localparam int TX_DEPTH = 64;
   localparam int TX_AW = 6;
   localparam int CNT_W = 7;
   localparam int PHY_ADDR_W = 5;
   localparam int PHY_REG_W = 5;
   localparam int PHY_DATA_W = 16;
   localparam int MDC_DIV = 40;
   localparam int MDC_DIV_W = 6;
   localparam int FRAME_BITS = 64;
   localparam int BIT_CNT_W = 7;
   localparam logic [MDC_DIV_W-1:0] MDC_HALF = 6'h14;
   localparam logic [BIT_CNT_W-1:0] BIT_LAST = 7'h3F;
   localparam logic [BIT_CNT_W-1:0] TA_BIT = 7'h2E;
   localparam logic [BIT_CNT_W-1:0] RD_FIRST = 7'h30;
   localparam logic [31:0] PREAMBLE = 32'hFFFF_FFFF;
   localparam logic [1:0] START_CODE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] TA_WRITE = 2'h2;
   localparam logic [PHY_ADDR_W-1:0] PHY_ADDR_RESET = 5'h00;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01,
      TX_DONE = 2'b10
   } tx_state_type;
endpackage

// ---- mgmt_if.sv ----
// interface: management request and answer between main block and serial engine
`timescale 1ns/10ps
interface mgmt_if;
   logic start;
   logic write;
   logic [4:0] phy_addr;
   logic [4:0] reg_addr;
   logic [15:0] wdata;
   logic busy;
   logic done;
   logic [15:0] rdata;
   modport ctrl (output start, write, phy_addr, reg_addr, wdata, input busy, done, rdata);
   modport eng (input start, write, phy_addr, reg_addr, wdata, output busy, done, rdata);
endinterface

// ---- mgmt_serial.sv ----
// module: serial management engine that shifts one frame to the phy
`timescale 1ns/10ps
module mgmt_serial (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   mgmt_if.eng m,
   input wire logic mdio_i,
   output logic mdc_o,
   output logic mdio_o,
   output logic mdio_oe_o
);
   import eth_pkt_pkg::*;
   typedef struct packed {
      logic busy;
      logic done;
      logic write;
      logic [MDC_DIV_W-1:0] div;
      logic [BIT_CNT_W-1:0] bitn;
      logic [FRAME_BITS-1:0] shreg;
      logic [PHY_DATA_W-1:0] rdata;
      logic mdc;
      logic mdio;
      logic oe;
   } ser_type;
   ser_type r, next_r;
   //////////////////////////////////////////////////////////////////////
   // next state: frame load, clock divider, shift
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      if (!r.busy) begin
         if (m.start) begin
            // busy from issue until the last bit leaves
            next_r.busy = 1'b1;
            next_r.write = m.write;
            next_r.div = '0;
            next_r.bitn = '0;
            next_r.mdc = 1'b0;
            next_r.shreg = {PREAMBLE, START_CODE, (m.write ? OP_WRITE : OP_READ), m.phy_addr, m.reg_addr,
                            TA_WRITE, m.wdata};
         end
      end else if (r.div == MDC_HALF - 1'b1) begin
         next_r.div = '0;
         next_r.mdc = ~r.mdc;
         if (!r.mdc) begin
            // rising edge: phy samples, we capture read data bits
            if (!r.write && r.bitn >= RD_FIRST) begin
               next_r.rdata = {r.rdata[PHY_DATA_W-2:0], mdio_i}; // 16-bit result
            end
         end else begin
            // falling edge: present next bit
            next_r.shreg = {r.shreg[FRAME_BITS-2:0], 1'b0};
            next_r.bitn = r.bitn + 1'b1;
            if (r.bitn == BIT_LAST) begin
               next_r.busy = 1'b0;
               next_r.done = 1'b1; // result valid only now
            end
         end
      end else begin
         next_r.div = r.div + 1'b1;
      end
      next_r.mdio = next_r.shreg[FRAME_BITS-1];
      // release the line for turnaround and data on reads
      next_r.oe = next_r.busy && (next_r.write || next_r.bitn < TA_BIT);
   end
   //////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign m.busy = r.busy;
   assign m.done = r.done;
   assign m.rdata = r.rdata;
   assign mdc_o = r.mdc;
   assign mdio_o = r.mdio;
   assign mdio_oe_o = r.oe;
endmodule

// ---- phy_mgmt_model.sv ----
// model: phy end of the serial management link with a register file
`timescale 1ns/10ps
module phy_mgmt_model #(parameter logic [4:0] PHY_AT = 5'h03) (
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_o
);
   logic [15:0] regs [32];
   logic [15:0] hd; // shifted frame bits
   logic [4:0] ra;
   logic rd, wr;
   int ones = 0;
   int n = 0; // index of next frame bit, 0 while hunting preamble
   initial begin
      mdio_o = 1'b1;
      mdio_oe_o = 1'b0;
   end
   // frames are taken on the rising clock edge, read data launched just after it
   always @(posedge mdc_i) begin
      if (n == 0) begin
         if (mdio_i) begin
            ones++;
         end else begin
            if (ones >= 32) begin
               n = 33;
               hd = 16'h0000;
            end
            ones = 0;
         end
      end else begin
         hd = {hd[14:0], mdio_i};
         if (n == 45) begin
            rd = hd[11:10] == 2'h2 && hd[9:5] == PHY_AT;
            wr = hd[11:10] == 2'h1 && hd[9:5] == PHY_AT;
            ra = hd[4:0];
         end
         if (n >= 47 && n <= 62 && rd) begin
            mdio_o = regs[ra][62-n];
            mdio_oe_o = 1'b1;
         end
         if (n == 63) begin
            if (wr) begin
               regs[ra] = hd;
            end
            mdio_oe_o = 1'b0;
            mdio_o = 1'b1;
            n = 0;
         end else begin
            n++;
         end
      end
   end
endmodule
